// ### inc/pnlcm_map.svh
// pnlcm_map.svh: offsets, field positions, reset values and counts
// assumes: included by bare name from the package and the design modules
`ifndef PNLCM_MAP_SVH
`define PNLCM_MAP_SVH

// ----------------------------------------------------------------
// register indices and byte addresses (four times the index)
// ----------------------------------------------------------------
`define PNLCM_IDX_NOLOAD 16'hE608
`define PNLCM_IDX_COMP 16'hE60E
`define PNLCM_ADDR_NOLOAD {`PNLCM_IDX_NOLOAD, 2'h0}
`define PNLCM_ADDR_COMP {`PNLCM_IDX_COMP, 2'h0}

// ----------------------------------------------------------------
// phase_noload_status fields
// ----------------------------------------------------------------
`define PNLCM_NL_TOTAL_LSB 0
`define PNLCM_NL_FUND_LSB 3
`define PNLCM_NL_APPAR_LSB 6
`define PNLCM_NL_USED_W 9
`define PNLCM_NL_RESET 9'h000

// ----------------------------------------------------------------
// computation_mode fields
// ----------------------------------------------------------------
`define PNLCM_CM_SEL1_LSB 0
`define PNLCM_CM_SEL2_LSB 3
`define PNLCM_CM_SEL3_LSB 6
`define PNLCM_CM_ANGLE_LSB 9
`define PNLCM_CM_USED_W 11
`define PNLCM_CM_SEL_RESET 9'h1FF

// ----------------------------------------------------------------
// pulse generation
// ----------------------------------------------------------------
`define PNLCM_ENERGY_W 16
`define PNLCM_ACC_W 24
`define PNLCM_PULSE_THRESH 24'h010000

`endif

// ### inc/pnlcm_pkg.sv
// pnlcm_pkg: types shared by the no-load and computation-mode block
// assumes: pnlcm_map.svh on the include path
package pnlcm_pkg;
    `include "pnlcm_map.svh"

    // ----------------------------------------------------------------
    // angle measurement selection
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PNLCM_ANG_V_I,
        PNLCM_ANG_V_V,
        PNLCM_ANG_I_I,
        PNLCM_ANG_NONE
    } pnlcm_angle_e;

    typedef logic [`PNLCM_ENERGY_W-1:0] pnlcm_energy_t;
endpackage : pnlcm_pkg

// ### rtl/pnlcm_pulse_acc.sv
// pnlcm_pulse_acc: accumulates selected phase energies into one pulse output
// assumes: energy increments are per-cycle, unsigned, synchronous to clock
`timescale 1ns/1ps
`include "pnlcm_map.svh"
module pnlcm_pulse_acc (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic [2:0] i_phase_select,
    input wire pnlcm_pkg::pnlcm_energy_t i_energy_a,
    input wire pnlcm_pkg::pnlcm_energy_t i_energy_b,
    input wire pnlcm_pkg::pnlcm_energy_t i_energy_c,
    output logic o_pulse
);
    import pnlcm_pkg::*;

    logic [`PNLCM_ACC_W-1:0] acc_r;
    logic [`PNLCM_ACC_W-1:0] acc_nxt;
    logic pulse_r;
    logic pulse_nxt;
    logic [`PNLCM_ACC_W-1:0] sum;
    logic [`PNLCM_ACC_W-1:0] total;

    // ----------------------------------------------------------------
    // accumulate and emit
    // ----------------------------------------------------------------
    always_comb begin
        sum = (i_phase_select[0] ? `PNLCM_ACC_W'(i_energy_a) : '0)
            + (i_phase_select[1] ? `PNLCM_ACC_W'(i_energy_b) : '0)
            + (i_phase_select[2] ? `PNLCM_ACC_W'(i_energy_c) : '0);
        total = acc_r + sum;
        if (total >= `PNLCM_PULSE_THRESH) begin
            acc_nxt = total - `PNLCM_PULSE_THRESH;
            pulse_nxt = 1'b1;
        end else begin
            acc_nxt = total;
            pulse_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            acc_r <= '0;
            pulse_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign o_pulse = pulse_r;
endmodule : pnlcm_pulse_acc

// ### rtl/pnlcm_regs.sv
// pnlcm_regs: per-phase no-load status and computation-mode registers on apb
// assumes: no-load detector levels and variant straps are synchronous inputs
`timescale 1ns/1ps
`include "pnlcm_map.svh"
module pnlcm_regs (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [17:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [2:0] i_total_act_noload,
    input wire logic [2:0] i_total_react_noload,
    input wire logic [2:0] i_fund_act_noload,
    input wire logic [2:0] i_fund_react_noload,
    input wire logic [2:0] i_apparent_noload,
    input wire logic i_variant_active_only,
    input wire logic i_variant_has_fund,
    input wire pnlcm_pkg::pnlcm_energy_t i_energy_a,
    input wire pnlcm_pkg::pnlcm_energy_t i_energy_b,
    input wire pnlcm_pkg::pnlcm_energy_t i_energy_c,
    output logic o_total_noload_event,
    output logic o_fund_noload_event,
    output logic o_apparent_noload_event,
    output logic o_first_pulse_output,
    output logic o_second_pulse_output,
    output logic o_third_pulse_output,
    output logic o_angle_v_i_en,
    output logic o_angle_v_v_en,
    output logic o_angle_i_i_en
);
    import pnlcm_pkg::*;

    // ----------------------------------------------------------------
    // no-load flags and events
    // ----------------------------------------------------------------
    logic [2:0] total_noload_phase_flag_r;
    logic [2:0] total_noload_phase_flag_nxt;
    logic [2:0] fund_noload_phase_flag_r;
    logic [2:0] fund_noload_phase_flag_nxt;
    logic [2:0] apparent_noload_phase_flag_r;
    logic [2:0] apparent_noload_phase_flag_nxt;
    logic total_event_r;
    logic total_event_nxt;
    logic fund_event_r;
    logic fund_event_nxt;
    logic appar_event_r;
    logic appar_event_nxt;

    always_comb begin
        total_noload_phase_flag_nxt = i_total_act_noload
            & (i_total_react_noload | {3{i_variant_active_only}});
        fund_noload_phase_flag_nxt = i_fund_act_noload & i_fund_react_noload
            & {3{i_variant_has_fund}};
        apparent_noload_phase_flag_nxt = i_apparent_noload;
        total_event_nxt = |(total_noload_phase_flag_nxt & ~total_noload_phase_flag_r);
        fund_event_nxt = |(fund_noload_phase_flag_nxt & ~fund_noload_phase_flag_r);
        appar_event_nxt = |(apparent_noload_phase_flag_nxt & ~apparent_noload_phase_flag_r);
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            total_noload_phase_flag_r <= 3'h0;
            fund_noload_phase_flag_r <= 3'h0;
            apparent_noload_phase_flag_r <= 3'h0;
            total_event_r <= 1'b0;
            fund_event_r <= 1'b0;
            appar_event_r <= 1'b0;
        end else begin
            total_noload_phase_flag_r <= total_noload_phase_flag_nxt;
            fund_noload_phase_flag_r <= fund_noload_phase_flag_nxt;
            apparent_noload_phase_flag_r <= apparent_noload_phase_flag_nxt;
            total_event_r <= total_event_nxt;
            fund_event_r <= fund_event_nxt;
            appar_event_r <= appar_event_nxt;
        end
    end

    // ----------------------------------------------------------------
    // apb slave and computation mode
    // ----------------------------------------------------------------
    logic [8:0] phase_select_r;
    logic [8:0] phase_select_nxt;
    pnlcm_angle_e angle_measure_select_r;
    pnlcm_angle_e angle_measure_select_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic [2:0] angle_en_r;
    logic [2:0] angle_en_nxt;
    logic [15:0] phase_noload_status;
    logic [15:0] computation_mode;
    logic setup;
    logic wr_done;

    assign phase_noload_status = {7'h00, apparent_noload_phase_flag_r,
                                  fund_noload_phase_flag_r, total_noload_phase_flag_r};
    assign computation_mode = {5'h00, angle_measure_select_r, phase_select_r};
    assign setup = i_psel & ~i_penable;
    assign wr_done = i_psel & i_penable & pready_r & i_pwrite;

    always_comb begin
        phase_select_nxt = phase_select_r;
        angle_measure_select_nxt = angle_measure_select_r;
        prdata_nxt = prdata_r;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        if (setup) begin
            pready_nxt = 1'b1;
            unique case (i_paddr)
                `PNLCM_ADDR_NOLOAD: prdata_nxt = {16'h0000, phase_noload_status};
                `PNLCM_ADDR_COMP: prdata_nxt = {16'h0000, computation_mode};
                default: begin
                    prdata_nxt = 32'h00000000;
                    pslverr_nxt = 1'b1;
                end
            endcase
        end
        if (wr_done && i_paddr == `PNLCM_ADDR_COMP) begin
            phase_select_nxt = i_pwdata[8:0];
            angle_measure_select_nxt = pnlcm_angle_e'(i_pwdata[10:9]);
        end
        unique case (angle_measure_select_r)
            PNLCM_ANG_V_I: angle_en_nxt = 3'h1;
            PNLCM_ANG_V_V: angle_en_nxt = 3'h2;
            PNLCM_ANG_I_I: angle_en_nxt = 3'h4;
            PNLCM_ANG_NONE: angle_en_nxt = 3'h0;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            phase_select_r <= `PNLCM_CM_SEL_RESET;
            angle_measure_select_r <= PNLCM_ANG_V_I;
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            angle_en_r <= 3'h0;
        end else begin
            phase_select_r <= phase_select_nxt;
            angle_measure_select_r <= angle_measure_select_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            angle_en_r <= angle_en_nxt;
        end
    end

    // ----------------------------------------------------------------
    // pulse outputs
    // ----------------------------------------------------------------
    logic [2:0] pulse;

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_pulse
            pnlcm_pulse_acc pnlcm_pulse_acc_inst (
                .i_core_clk(i_core_clk),
                .i_resetn(i_resetn),
                .i_phase_select(phase_select_r[3*g +: 3]),
                .i_energy_a(i_energy_a),
                .i_energy_b(i_energy_b),
                .i_energy_c(i_energy_c),
                .o_pulse(pulse[g])
            );
        end
    endgenerate

    assign o_first_pulse_output = pulse[0];
    assign o_second_pulse_output = pulse[1];
    assign o_third_pulse_output = pulse[2];
    assign o_prdata = prdata_r;
    assign o_pready = pready_r;
    assign o_pslverr = pslverr_r;
    assign o_total_noload_event = total_event_r;
    assign o_fund_noload_event = fund_event_r;
    assign o_apparent_noload_event = appar_event_r;
    assign o_angle_v_i_en = angle_en_r[0];
    assign o_angle_v_v_en = angle_en_r[1];
    assign o_angle_i_i_en = angle_en_r[2];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_comp_write(logic [1:0] ang);
        wr_done && i_paddr == `PNLCM_ADDR_COMP && i_pwdata[10:9] == ang;
    endsequence

    property p_total_flag;
        @(posedge i_core_clk) disable iff (!i_resetn)
        !i_variant_active_only |=> total_noload_phase_flag_r == $past(i_total_act_noload & i_total_react_noload);
    endproperty
    a_total_flag: assert property (p_total_flag) else $error("total flag mismatch");

    property p_total_event;
        @(posedge i_core_clk) disable iff (!i_resetn)
        |(total_noload_phase_flag_r & ~$past(total_noload_phase_flag_r)) |-> o_total_noload_event;
    endproperty
    a_total_event: assert property (p_total_event) else $error("total event missing");

    property p_active_only;
        @(posedge i_core_clk) disable iff (!i_resetn)
        i_variant_active_only |=> total_noload_phase_flag_r == $past(i_total_act_noload);
    endproperty
    a_active_only: assert property (p_active_only) else $error("reactive not ignored");

    property p_fund_flag;
        @(posedge i_core_clk) disable iff (!i_resetn)
        i_variant_has_fund |=> fund_noload_phase_flag_r == $past(i_fund_act_noload & i_fund_react_noload);
    endproperty
    a_fund_flag: assert property (p_fund_flag) else $error("fund flag mismatch");

    property p_fund_event;
        @(posedge i_core_clk) disable iff (!i_resetn)
        o_fund_noload_event == |(fund_noload_phase_flag_r & ~$past(fund_noload_phase_flag_r));
    endproperty
    a_fund_event: assert property (p_fund_event) else $error("fund event mismatch");

    property p_no_fund;
        @(posedge i_core_clk) disable iff (!i_resetn)
        !i_variant_has_fund [*2] |-> fund_noload_phase_flag_r == 3'h0;
    endproperty
    a_no_fund: assert property (p_no_fund) else $error("fund flag set in variant");

    property p_appar_event;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (i_apparent_noload & ~apparent_noload_phase_flag_r) != 3'h0 |=>
            o_apparent_noload_event && apparent_noload_phase_flag_r != 3'h0;
    endproperty
    a_appar_event: assert property (p_appar_event) else $error("apparent event missing");

    property p_status_read;
        @(posedge i_core_clk) disable iff (!i_resetn)
        setup && i_paddr == `PNLCM_ADDR_NOLOAD |=> o_pready && o_prdata[31:9] == 23'h0 && !o_pslverr;
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read bad");

    property p_angle_vv;
        @(posedge i_core_clk) disable iff (!i_resetn)
        s_comp_write(2'h1) ##1 1 |=> o_angle_v_v_en && !o_angle_v_i_en && !o_angle_i_i_en;
    endproperty
    a_angle_vv: assert property (p_angle_vv) else $error("voltage angles not selected");

    property p_angle_none;
        @(posedge i_core_clk) disable iff (!i_resetn)
        s_comp_write(2'h3) ##2 1 |-> angle_en_r == 3'h0;
    endproperty
    a_angle_none: assert property (p_angle_none) else $error("angles not off");

    property p_status_wr;
        @(posedge i_core_clk) disable iff (!i_resetn)
        wr_done && i_paddr == `PNLCM_ADDR_NOLOAD |=> apparent_noload_phase_flag_r == $past(i_apparent_noload)
            && $stable(phase_select_r) && $stable(angle_measure_select_r);
    endproperty
    a_status_wr: assert property (p_status_wr) else $error("status write had effect");
endmodule : pnlcm_regs

// ### verification/pnlcm_regs_tb.sv
// pnlcm_regs_tb: self-checking bench for the no-load status and computation-mode registers
// assumes: zero-wait apb slave, detector levels sampled every edge, 25 MHz core clock
`timescale 1ns/1ps
`include "pnlcm_map.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
    $display("BAD %0t got %h exp %h", $time, got, exp); end end
module pnlcm_regs_tb;
    import pnlcm_pkg::*;
    // ----------------------------------------------------------------
    // stimulus and observation signals
    // ----------------------------------------------------------------
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic pready, pslverr;
    logic [2:0] tact = 3'h0, treact = 3'h0, fact = 3'h0, freact = 3'h0, app = 3'h0;
    logic act_only = 1'b0, has_fund = 1'b1;
    pnlcm_energy_t en_a = 16'h0000, en_b = 16'h0000, en_c = 16'h0000;
    logic ev_tot, ev_fund, ev_app, cf1, cf2, cf3, ang_vi, ang_vv, ang_ii;
    int n_errors = 0, n_tests = 0, c1 = 0, c2 = 0, c3 = 0;
    logic [31:0] rd;
    logic err;
    pnlcm_regs pnlcm_regs_inst (
        .i_core_clk(core_clk), .i_resetn(resetn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_total_act_noload(tact),
        .i_total_react_noload(treact), .i_fund_act_noload(fact), .i_fund_react_noload(freact),
        .i_apparent_noload(app), .i_variant_active_only(act_only), .i_variant_has_fund(has_fund),
        .i_energy_a(en_a), .i_energy_b(en_b), .i_energy_c(en_c),
        .o_total_noload_event(ev_tot), .o_fund_noload_event(ev_fund),
        .o_apparent_noload_event(ev_app), .o_first_pulse_output(cf1),
        .o_second_pulse_output(cf2), .o_third_pulse_output(cf3),
        .o_angle_v_i_en(ang_vi), .o_angle_v_v_en(ang_vv), .o_angle_i_i_en(ang_ii)
    );
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        c1 <= c1 + int'(cf1);
        c2 <= c2 + int'(cf2);
        c3 <= c3 + int'(cf3);
    end
    // ----------------------------------------------------------------
    // closing report
    // ----------------------------------------------------------------
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    // ----------------------------------------------------------------
    // apb master
    // ----------------------------------------------------------------
    task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_errors++;
            $display("BAD %0t apb wait ran out", $time);
            finish_test();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb
    task automatic rd_chk(input logic [17:0] a, input logic [31:0] exp, input logic exp_err);
        apb(1'b0, a, 32'h00000000);
        `CHK(rd, exp)
        `CHK(err, exp_err)
    endtask : rd_chk
    task automatic wait_clk(input int n);
        repeat (n) @(posedge core_clk);
    endtask : wait_clk
    // ----------------------------------------------------------------
    // no-load case table: {tact,treact,fact,freact,app}, straps, status, {app,fund,tot} event
    // ----------------------------------------------------------------
    typedef struct {logic [14:0] nl; logic ao; logic hf; logic [31:0] st; logic [2:0] ev;} pnlcm_case_s;
    pnlcm_case_s cases[7] = '{
        '{15'h2000, 1'b0, 1'b1, 32'h00000000, 3'h0},
        '{15'h2400, 1'b0, 1'b1, 32'h00000002, 3'h1},
        '{15'h5000, 1'b1, 1'b1, 32'h00000005, 3'h1},
        '{15'h0120, 1'b0, 1'b1, 32'h00000020, 3'h2},
        '{15'h01F8, 1'b0, 1'b0, 32'h00000000, 3'h0},
        '{15'h0001, 1'b0, 1'b1, 32'h00000040, 3'h4},
        '{15'h7FFF, 1'b0, 1'b1, 32'h000001FF, 3'h7}
    };
    logic [2:0] ang_exp[4] = '{3'h1, 3'h2, 3'h4, 3'h0};
    initial begin
        wait_clk(20);
        resetn <= 1'b1;
        wait_clk(2);
        #1;
        `CHK({ang_ii, ang_vv, ang_vi}, 3'h1)
        rd_chk(`PNLCM_ADDR_NOLOAD, 32'h00000000, 1'b0);
        rd_chk(`PNLCM_ADDR_COMP, 32'h000001FF, 1'b0);
        rd_chk({16'hE604, 2'h0}, 32'h00000000, 1'b1);
        $display("reset and map test done");
        apb(1'b1, `PNLCM_ADDR_NOLOAD, 32'h0000FFFF);
        `CHK(err, 1'b0)
        rd_chk(`PNLCM_ADDR_NOLOAD, 32'h00000000, 1'b0);
        $display("status write test done");
        for (int i = 0; i < 7; i++) begin
            @(posedge core_clk);
            {tact, treact, fact, freact, app} <= 15'h0000;
            act_only <= cases[i].ao;
            has_fund <= cases[i].hf;
            wait_clk(2);
            {tact, treact, fact, freact, app} <= cases[i].nl;
            @(posedge core_clk);
            #1;
            `CHK({ev_app, ev_fund, ev_tot}, cases[i].ev)
            @(posedge core_clk);
            #1;
            `CHK({ev_app, ev_fund, ev_tot}, 3'h0)
            rd_chk(`PNLCM_ADDR_NOLOAD, cases[i].st, 1'b0);
        end
        @(posedge core_clk);
        {tact, treact, fact, freact, app} <= 15'h0000;
        wait_clk(2);
        rd_chk(`PNLCM_ADDR_NOLOAD, 32'h00000000, 1'b0);
        $display("no-load test done");
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, `PNLCM_ADDR_COMP, {21'h000000, 2'(k), 9'h1FF});
            @(posedge core_clk);
            #1;
            `CHK({ang_ii, ang_vv, ang_vi}, ang_exp[k])
            rd_chk(`PNLCM_ADDR_COMP, {21'h000000, 2'(k), 9'h1FF}, 1'b0);
        end
        apb(1'b1, `PNLCM_ADDR_COMP, 32'hFFFFFFFF);
        rd_chk(`PNLCM_ADDR_COMP, 32'h000007FF, 1'b0);
        $display("computation mode test done");
        apb(1'b1, `PNLCM_ADDR_COMP, 32'h000001D1);
        wait_clk(2);
        en_a <= 16'h1000;
        en_b <= 16'h2000;
        en_c <= 16'h1000;
        wait_clk(64);
        en_a <= 16'h0000;
        en_b <= 16'h0000;
        en_c <= 16'h0000;
        wait_clk(4);
        `CHK(c1, 4)
        `CHK(c2, 8)
        `CHK(c3, 16)
        $display("pulse test done");
        finish_test();
    end
endmodule : pnlcm_regs_tb
